// [logic/lmpw_top.sv]
// lmpw_top: long-mode page walker with canonical check and APB control registers.
// assumes memory answers each held table read with one memRspValid pulse and a 64-bit entry.
`timescale 1ns/10ps
module lmpw_top #(
  parameter int VA_BITS    = lmpw_pkg::VA_BITS_DEF,
  parameter int PA_BITS    = lmpw_pkg::PA_BITS_DEF,
  parameter int HUGE_PAGES = lmpw_pkg::HUGE_PAGES_DEF
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [11:0]        paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               xreqValid,
  input  wire lmpw_pkg::lmpw_xreq_s xreq,
  output logic                    xreqReady,
  output logic                    xrspValid,
  output lmpw_pkg::lmpw_xrsp_s    xrsp,
  output logic                    memReqValid,
  output lmpw_pkg::lmpw_mreq_s    memReq,
  input  wire logic               memRspValid,
  input  wire logic [63:0]        memRdata
);

  // supported virtual width must keep four levels of 9-bit indices
  if (VA_BITS < 40 || VA_BITS > 48) begin : gVaCheck
    $error("VA_BITS must lie between 40 and 48");
  end
  if (PA_BITS < 32 || PA_BITS > 52) begin : gPaCheck
    $error("PA_BITS must lie between 32 and 52");
  end
  if (HUGE_PAGES < 0 || HUGE_PAGES > 1) begin : gHugeCheck
    $error("HUGE_PAGES must be 0 or 1");
  end

  localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] CANON_ONES = ALL_ONES >> (VA_BITS - 1);
  localparam logic [8:0]  TOP_MASK = 9'h1ff >> (48 - VA_BITS);
  localparam logic [51:0] PA_MASK = 52'hf_ffff_ffff_ffff >> (52 - PA_BITS);

  typedef struct packed {
    lmpw_pkg::lmpw_state_e st;
    logic [63:0]           root;
    logic                  pae;
    logic                  lme;
    logic                  pse;
    logic                  actFault;
    logic [63:0]           vaddr;
    logic                  isStack;
    logic                  nxAcc;
    logic                  memReqValid;
    lmpw_pkg::lmpw_mreq_s  memReq;
    logic                  xreqReady;
    logic                  xrspValid;
    lmpw_pkg::lmpw_xrsp_s  xrsp;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } lmpw_regs_s;

  lmpw_regs_s s;
  lmpw_regs_s next_s;
  logic [1:0] rstSync;
  logic       rstSyncN;

  // reset enters asynchronously but releases through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  // merge one write word into a register under the byte strobes
  function automatic logic [31:0] strbMerge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // entry base masked to the supported width, low 12 bits forced to zero
  function automatic logic [51:0] entryBase(input logic [63:0] ent);
    logic [51:0] b;
    b = ent[lmpw_pkg::BASE_HI:0] & PA_MASK;
    b[lmpw_pkg::BASE_LO-1:0] = 12'h000;
    return b;
  endfunction

  // next table address: base from entry, 9-bit index, 8-byte entry slot
  function automatic logic [51:0] tableAddr(
    input logic [63:0] ent,
    input logic [8:0]  idx
  );
    logic [51:0] b;
    b = entryBase(ent);
    return {b[lmpw_pkg::BASE_HI:lmpw_pkg::BASE_LO], idx, 3'h0};
  endfunction

  logic        canon;
  logic [63:0] hiBits;
  logic [8:0]  idxTop;
  logic [8:0]  idxPtr;
  logic [8:0]  idxDir;
  logic [8:0]  idxLeaf;
  logic [51:0] entBase;
  logic        mapped;
  logic [31:0] rdWord;
  logic [31:0] ctrlWr;
  logic        apbSetup;
  logic        apbWrite;

  always_comb begin
    // bits at and above the top implemented bit must all match
    hiBits = xreq.vaddr >> (VA_BITS - 1);
    canon = (hiBits == 64'h0) || (hiBits == CANON_ONES);
    idxTop  = xreq.vaddr[lmpw_pkg::TOP_IDX_LO +: lmpw_pkg::IDX_W] & TOP_MASK;
    idxPtr  = s.vaddr[lmpw_pkg::PTR_IDX_LO +: lmpw_pkg::IDX_W];
    idxDir  = s.vaddr[lmpw_pkg::DIR_IDX_LO +: lmpw_pkg::IDX_W];
    idxLeaf = s.vaddr[lmpw_pkg::LEAF_IDX_LO +: lmpw_pkg::IDX_W];
    entBase = entryBase(memRdata);
    apbSetup = psel && !penable && !s.pready;
    apbWrite = psel && penable && s.pready && pwrite;
    mapped = (paddr == lmpw_pkg::OFF_ROOT_LO) || (paddr == lmpw_pkg::OFF_ROOT_HI) ||
             (paddr == lmpw_pkg::OFF_CTRL) || (paddr == lmpw_pkg::OFF_STATUS);
    unique case (paddr)
      lmpw_pkg::OFF_ROOT_LO: rdWord = s.root[31:0];
      lmpw_pkg::OFF_ROOT_HI: rdWord = s.root[63:32];
      lmpw_pkg::OFF_CTRL:    rdWord = {29'h0, s.pse, s.lme, s.pae};
      lmpw_pkg::OFF_STATUS:  rdWord = {29'h0, (s.st != lmpw_pkg::ST_IDLE),
                                       (s.lme && s.pae), s.actFault};
      default:               rdWord = 32'h0;
    endcase
    ctrlWr = strbMerge({29'h0, s.pse, s.lme, s.pae}, pwdata, pstrb);

    next_s = s;
    next_s.xrspValid = 1'b0;

    // apb: answer is registered in the setup cycle, ready in the access cycle
    next_s.pready = apbSetup;
    if (apbSetup) begin
      next_s.prdata = pwrite ? 32'h0 : rdWord;
      next_s.pslverr = !mapped;
    end else begin
      next_s.pslverr = 1'b0;
    end

    if (apbWrite && mapped) begin
      unique case (paddr)
        lmpw_pkg::OFF_ROOT_LO: begin
          // reserved and over-width bits are kept as written
          next_s.root[31:0] = strbMerge(s.root[31:0], pwdata, pstrb);
        end
        lmpw_pkg::OFF_ROOT_HI: begin
          next_s.root[63:32] = strbMerge(s.root[63:32], pwdata, pstrb);
        end
        lmpw_pkg::OFF_CTRL: begin
          next_s.pae = ctrlWr[lmpw_pkg::CTRL_PAE];
          // legacy large-page enable is held for software only; paging ignores it
          next_s.pse = ctrlWr[lmpw_pkg::CTRL_PSE];
          if (ctrlWr[lmpw_pkg::CTRL_LME] && !ctrlWr[lmpw_pkg::CTRL_PAE]) begin
            next_s.lme = 1'b0;
          end else begin
            next_s.lme = ctrlWr[lmpw_pkg::CTRL_LME];
          end
        end
        lmpw_pkg::OFF_STATUS: begin
          if (pstrb[0] && pwdata[lmpw_pkg::STAT_ACT_FAULT]) begin
            next_s.actFault = 1'b0;
          end
        end
        default: begin
          next_s.actFault = s.actFault;
        end
      endcase
    end
    // the set comes after the clear so a fresh fault is never lost
    if (apbWrite && paddr == lmpw_pkg::OFF_CTRL &&
        ctrlWr[lmpw_pkg::CTRL_LME] && !ctrlWr[lmpw_pkg::CTRL_PAE]) begin
      next_s.actFault = 1'b1;
    end

    unique case (s.st)
      lmpw_pkg::ST_IDLE: begin
        if (xreqValid && s.xreqReady) begin
          next_s.vaddr = xreq.vaddr;
          next_s.isStack = xreq.isStack;
          next_s.nxAcc = 1'b0;
          if (!canon) begin
            next_s.st = lmpw_pkg::ST_RESP;
            next_s.xrspValid = 1'b1;
            next_s.xrsp.paddr = '0;
            next_s.xrsp.size = lmpw_pkg::SZ_4K;
            next_s.xrsp.noExecute = 1'b0;
            next_s.xrsp.fault = xreq.isStack ? lmpw_pkg::FLT_SS : lmpw_pkg::FLT_GP;
          end else begin
            // the root is sampled here so a later write cannot tear this walk
            next_s.st = lmpw_pkg::ST_TOP;
            next_s.memReqValid = 1'b1;
            next_s.memReq.addr = tableAddr(s.root, idxTop);
            next_s.memReq.writethrough = s.root[lmpw_pkg::ROOT_WT_BIT];
            next_s.memReq.cacheDisable = s.root[lmpw_pkg::ROOT_CD_BIT];
          end
        end
      end
      lmpw_pkg::ST_TOP: begin
        if (memRspValid) begin
          // top-level entry: next-table base in 51..12, no-execute in 63
          next_s.nxAcc = s.nxAcc | memRdata[lmpw_pkg::ENT_NX_BIT];
          next_s.st = lmpw_pkg::ST_PTR;
          next_s.memReq.addr = tableAddr(memRdata, idxPtr);
          next_s.memReq.writethrough = memRdata[lmpw_pkg::ENT_WT_BIT];
          next_s.memReq.cacheDisable = memRdata[lmpw_pkg::ENT_CD_BIT];
        end
      end
      lmpw_pkg::ST_PTR: begin
        if (memRspValid) begin
          next_s.nxAcc = s.nxAcc | memRdata[lmpw_pkg::ENT_NX_BIT];
          if (HUGE_PAGES == 1 && memRdata[lmpw_pkg::ENT_PS_BIT]) begin
            next_s.st = lmpw_pkg::ST_RESP;
            next_s.memReqValid = 1'b0;
            next_s.xrspValid = 1'b1;
            next_s.xrsp.fault = lmpw_pkg::FLT_NONE;
            next_s.xrsp.size = lmpw_pkg::SZ_1G;
            next_s.xrsp.noExecute = s.nxAcc | memRdata[lmpw_pkg::ENT_NX_BIT];
            next_s.xrsp.paddr = {entBase[51:lmpw_pkg::OFF_1G_W],
                                 s.vaddr[lmpw_pkg::OFF_1G_W-1:0]};
          end else begin
            next_s.st = lmpw_pkg::ST_DIR;
            next_s.memReq.addr = tableAddr(memRdata, idxDir);
            next_s.memReq.writethrough = memRdata[lmpw_pkg::ENT_WT_BIT];
            next_s.memReq.cacheDisable = memRdata[lmpw_pkg::ENT_CD_BIT];
          end
        end
      end
      lmpw_pkg::ST_DIR: begin
        if (memRspValid) begin
          next_s.nxAcc = s.nxAcc | memRdata[lmpw_pkg::ENT_NX_BIT];
          if (memRdata[lmpw_pkg::ENT_PS_BIT]) begin
            next_s.st = lmpw_pkg::ST_RESP;
            next_s.memReqValid = 1'b0;
            next_s.xrspValid = 1'b1;
            next_s.xrsp.fault = lmpw_pkg::FLT_NONE;
            next_s.xrsp.size = lmpw_pkg::SZ_2M;
            next_s.xrsp.noExecute = s.nxAcc | memRdata[lmpw_pkg::ENT_NX_BIT];
            next_s.xrsp.paddr = {entBase[51:lmpw_pkg::OFF_2M_W],
                                 s.vaddr[lmpw_pkg::OFF_2M_W-1:0]};
          end else begin
            next_s.st = lmpw_pkg::ST_LEAF;
            next_s.memReq.addr = tableAddr(memRdata, idxLeaf);
            next_s.memReq.writethrough = memRdata[lmpw_pkg::ENT_WT_BIT];
            next_s.memReq.cacheDisable = memRdata[lmpw_pkg::ENT_CD_BIT];
          end
        end
      end
      lmpw_pkg::ST_LEAF: begin
        if (memRspValid) begin
          next_s.st = lmpw_pkg::ST_RESP;
          next_s.memReqValid = 1'b0;
          next_s.xrspValid = 1'b1;
          next_s.xrsp.fault = lmpw_pkg::FLT_NONE;
          next_s.xrsp.size = lmpw_pkg::SZ_4K;
          next_s.xrsp.noExecute = s.nxAcc | memRdata[lmpw_pkg::ENT_NX_BIT];
          next_s.xrsp.paddr = {entBase[51:lmpw_pkg::OFF_4K_W],
                               s.vaddr[lmpw_pkg::OFF_4K_W-1:0]};
        end
      end
      lmpw_pkg::ST_RESP: begin
        next_s.st = lmpw_pkg::ST_IDLE;
      end
      default: begin
        next_s.st = lmpw_pkg::ST_IDLE;
        next_s.memReqValid = 1'b0;
      end
    endcase

    // new requests only in long mode, and only once the walker is idle
    next_s.xreqReady = (next_s.st == lmpw_pkg::ST_IDLE) && next_s.lme && next_s.pae;
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= '{st: lmpw_pkg::ST_IDLE,
             root: lmpw_pkg::ROOT_RST,
             pae: lmpw_pkg::CTRL_RST[lmpw_pkg::CTRL_PAE],
             lme: lmpw_pkg::CTRL_RST[lmpw_pkg::CTRL_LME],
             pse: lmpw_pkg::CTRL_RST[lmpw_pkg::CTRL_PSE],
             actFault: 1'b0,
             vaddr: 64'h0,
             isStack: 1'b0,
             nxAcc: 1'b0,
             memReqValid: 1'b0,
             memReq: '0,
             xreqReady: 1'b0,
             xrspValid: 1'b0,
             xrsp: '0,
             pready: 1'b0,
             pslverr: 1'b0,
             prdata: 32'h0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign xreqReady   = s.xreqReady;
  assign xrspValid   = s.xrspValid;
  assign xrsp        = s.xrsp;
  assign memReqValid = s.memReqValid;
  assign memReq      = s.memReq;

endmodule // lmpw_top

// [shared/lmpw_pkg.sv]
// lmpw_pkg: constants, register map and carrier types of the long-mode page walker.
// assumes a single 125 MHz core clock and a 32-bit APB register port.
//
// Overview of operation
// - activating long mode while physical-address extension is off raises a protection fault
// - 64-bit virtual addresses map onto physical addresses of up to 52 bits
// - every fetched table entry is taken as one 64-bit word
// - the walk starts at the top-level table, whose entry selects the pointer table
// - directory large-page bit picks 4K or 2M; legacy large-page enable is ignored
// - with huge pages built in, a pointer entry page-size bit ends walk at 1G
// - canonical means bits from the top implemented bit through 63 all equal
// - a non-canonical reference faults: protection fault, or stack fault for stack references
// - root pointer bits 51..12 are the top-level base; low 12 bits are zero
// - root bit 3 picks writeback (0) or writethrough (1) for top-level reads
// - root bit 4 allows (0) or forbids (1) caching of top-level reads
// - virtual bits 63..48 must be copies of bit 47
// - virtual bits 47..39 index the 512-entry top-level table
// - virtual bits 38..30 index the 512-entry directory-pointer table
// - virtual bits 29..21 index the 512-entry directory table
// - for 4K pages virtual bits 20..12 index the 512-entry leaf table
// - for 4K pages virtual bits 11..0 pass through as the page offset
// - sign-extension and top-index widths follow the supported virtual address width
// - directory entry with bit 7 clear continues to a leaf table, 4K page
// - top-level entry: no-execute bit 63, available 62..52, base 51..12, bit 7 zero
// - for 2M pages virtual bits 20..0 pass through; no leaf table read
// - for 1G pages virtual bits 29..0 pass through; no directory or leaf read
package lmpw_pkg;

  localparam int VA_BITS_DEF = 48;
  localparam int PA_BITS_DEF = 52;
  localparam int HUGE_PAGES_DEF = 1;

  localparam logic [11:0] OFF_ROOT_LO = 12'h000;
  localparam logic [11:0] OFF_ROOT_HI = 12'h004;
  localparam logic [11:0] OFF_CTRL    = 12'h008;
  localparam logic [11:0] OFF_STATUS  = 12'h00c;

  localparam int CTRL_PAE = 0;
  localparam int CTRL_LME = 1;
  localparam int CTRL_PSE = 2;
  localparam int STAT_ACT_FAULT = 0;
  localparam int STAT_LMA = 1;
  localparam int STAT_BUSY = 2;

  localparam logic [63:0] ROOT_RST = 64'h0;
  localparam logic [2:0]  CTRL_RST = 3'h0;

  localparam int ROOT_WT_BIT = 3;
  localparam int ROOT_CD_BIT = 4;
  localparam int ENT_WT_BIT = 3;
  localparam int ENT_CD_BIT = 4;
  localparam int ENT_PS_BIT = 7;
  localparam int ENT_NX_BIT = 63;
  localparam int BASE_LO = 12;
  localparam int BASE_HI = 51;
  localparam int PADDR_W = 52;
  localparam int IDX_W = 9;
  localparam int TOP_IDX_LO = 39;
  localparam int PTR_IDX_LO = 30;
  localparam int DIR_IDX_LO = 21;
  localparam int LEAF_IDX_LO = 12;
  localparam int OFF_4K_W = 12;
  localparam int OFF_2M_W = 21;
  localparam int OFF_1G_W = 30;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TOP  = 3'h1,
    ST_PTR  = 3'h3,
    ST_DIR  = 3'h2,
    ST_LEAF = 3'h6,
    ST_RESP = 3'h7
  } lmpw_state_e;

  typedef enum logic [1:0] {
    FLT_NONE = 2'h0,
    FLT_GP   = 2'h1,
    FLT_SS   = 2'h2
  } lmpw_fault_e;

  typedef enum logic [1:0] {
    SZ_4K = 2'h0,
    SZ_2M = 2'h1,
    SZ_1G = 2'h2
  } lmpw_size_e;

  typedef struct packed {
    logic [63:0] vaddr;
    logic        isStack;
  } lmpw_xreq_s;

  typedef struct packed {
    logic [PADDR_W-1:0] paddr;
    lmpw_fault_e        fault;
    lmpw_size_e         size;
    logic               noExecute;
  } lmpw_xrsp_s;

  typedef struct packed {
    logic [PADDR_W-1:0] addr;
    logic               cacheDisable;
    logic               writethrough;
  } lmpw_mreq_s;

endpackage

// [test/lmpw_mem_model.sv]
// lmpw_mem_model: table memory answering one held read at a time.
// assumes memReqValid stays high between levels of one walk.
`timescale 1ns/10ps
module lmpw_mem_model (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 memReqValid,
  input  wire lmpw_pkg::lmpw_mreq_s memReq,
  input  wire logic [3:0]           psSel,
  input  wire logic                 slow,
  output logic                      memRspValid,
  output logic [63:0]               memRdata
);
  logic [1:0] lvl;
  logic [1:0] cnt;
  // entries are whole 64-bit words; top level keeps bit 7 clear
  function automatic logic [63:0] f_entry(input logic [51:0] a, input logic [1:0] l,
                                          input logic ps);
    f_entry = {a[5], 11'h0, a[31:0] ^ 32'h3c5a96e1, 6'h0, l, 4'h0, ps & (l != 2'h0),
               2'h0, a[4], a[3], 3'h1};
  endfunction
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memRspValid <= 1'b0;
      memRdata    <= '0;
      lvl         <= 2'h0;
      cnt         <= 2'h0;
    end else begin
      memRspValid <= 1'b0;
      // data line not valid: invert it every cycle so a stale word is never held steady
      memRdata <= ~memRdata;
      if (!memReqValid) begin
        lvl <= 2'h0;
        cnt <= 2'h0;
      end else if (!memRspValid) begin
        if (cnt == {slow, slow}) begin
          memRspValid <= 1'b1;
          memRdata    <= f_entry(memReq.addr, lvl, psSel[lvl]);
          lvl         <= lvl + 2'h1;
          cnt         <= 2'h0;
        end else cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // lmpw_mem_model

// [test/lmpw_top_sva.sv]
// lmpw_top_chk: port-level checks of the page walker.
// assumes full-word APB writes; the root value is rebuilt from them.
`timescale 1ns/10ps
module lmpw_top_chk #(
  parameter int VA_BITS    = 48,
  parameter int PA_BITS    = 52,
  parameter int HUGE_PAGES = 1
) (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic [11:0]          paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 xreqValid,
  input wire lmpw_pkg::lmpw_xreq_s xreq,
  input wire logic                 xreqReady,
  input wire logic                 xrspValid,
  input wire lmpw_pkg::lmpw_xrsp_s xrsp,
  input wire logic                 memReqValid,
  input wire lmpw_pkg::lmpw_mreq_s memReq,
  input wire logic                 memRspValid,
  input wire logic [63:0]          memRdata
);
  logic [63:0] root;
  logic [63:0] va;
  logic        stk;
  logic [1:0]  lvl;
  wire acc = xreqValid && xreqReady;
  wire wr  = psel && penable && pready && pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  function automatic logic canon(input logic [63:0] v);
    canon = (v >> (VA_BITS - 1)) == 64'h0 || (~v >> (VA_BITS - 1)) == 64'h0;
  endfunction
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      root <= '0;
      va   <= '0;
      stk  <= 1'b0;
      lvl  <= 2'h0;
    end else begin
      if (wr && paddr == lmpw_pkg::OFF_ROOT_LO) root[31:0] <= pwdata;
      if (wr && paddr == lmpw_pkg::OFF_ROOT_HI) root[63:32] <= pwdata;
      if (acc) begin
        va  <= xreq.vaddr;
        stk <= xreq.isStack;
        lvl <= 2'h0;
      end else if (memRspValid) lvl <= lvl + 2'h1;
    end
  end
  property p_bad_va;
    acc && !canon(xreq.vaddr) |=> xrspValid && !memReqValid &&
      xrsp.fault == (stk ? lmpw_pkg::FLT_SS : lmpw_pkg::FLT_GP);
  endproperty
  a_bad_va: assert property (p_bad_va) else $error("bad address not faulted");
  property p_good_va;
    acc && canon(xreq.vaddr) |=> memReqValid && !xrspValid;
  endproperty
  a_good_va: assert property (p_good_va) else $error("walk did not start");
  property p_top_addr;
    $rose(memReqValid) |-> memReq.addr == {root[51:12], va[47:39], 3'h0};
  endproperty
  a_top_addr: assert property (p_top_addr) else $error("top read address");
  property p_top_attr;
    $rose(memReqValid) |-> memReq.cacheDisable == root[4] && memReq.writethrough == root[3];
  endproperty
  a_top_attr: assert property (p_top_attr) else $error("top read attributes");
  property p_next;
    memRspValid && (lvl == 2'h0 || (lvl == 2'h1 && !(memRdata[7] && HUGE_PAGES != 0)) ||
      (lvl == 2'h2 && !memRdata[7])) |=> memReqValid && !xrspValid &&
      memReq.addr[51:12] == $past(memRdata[51:12]) && memReq.addr[11:3] == 9'(va >> (39 - 9 * lvl));
  endproperty
  a_next: assert property (p_next) else $error("next level address");
  property p_huge;
    memRspValid && lvl == 2'h1 && memRdata[7] && HUGE_PAGES != 0 |=> xrspValid &&
      xrsp.size == lmpw_pkg::SZ_1G && xrsp.paddr[29:0] == va[29:0];
  endproperty
  a_huge: assert property (p_huge) else $error("1G page");
  property p_large;
    memRspValid && lvl == 2'h2 && memRdata[7] |=> xrspValid &&
      xrsp.size == lmpw_pkg::SZ_2M && xrsp.paddr[20:0] == va[20:0];
  endproperty
  a_large: assert property (p_large) else $error("2M page");
  property p_small;
    memRspValid && lvl == 2'h3 |=> xrspValid && xrsp.size == lmpw_pkg::SZ_4K &&
      xrsp.paddr == {$past(memRdata[51:12]), va[11:0]};
  endproperty
  a_small: assert property (p_small) else $error("4K page");
  property p_act_fault;
    wr && paddr == lmpw_pkg::OFF_CTRL && pwdata[1] && !pwdata[0] |=> !xreqReady [*2];
  endproperty
  a_act_fault: assert property (p_act_fault) else $error("long mode without extension");
  property p_one_walk;
    memReqValid |-> !xreqReady && !xrspValid;
  endproperty
  a_one_walk: assert property (p_one_walk) else $error("accept while walking");
endmodule // lmpw_top_chk
bind lmpw_top lmpw_top_chk #(.VA_BITS(VA_BITS), .PA_BITS(PA_BITS), .HUGE_PAGES(HUGE_PAGES)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .xreqValid(xreqValid), .xreq(xreq),
  .xreqReady(xreqReady), .xrspValid(xrspValid), .xrsp(xrsp), .memReqValid(memReqValid),
  .memReq(memReq), .memRspValid(memRspValid), .memRdata(memRdata));

// [test/tb.sv]
// tb: register, activation and translation tests of the page walker.
// assumes the memory model's table contents stand in for real tables.
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic xreqValid = 1'b0;
  lmpw_pkg::lmpw_xreq_s xreq = '0;
  logic xreqReady;
  logic xrspValid;
  lmpw_pkg::lmpw_xrsp_s xrsp;
  logic memReqValid;
  lmpw_pkg::lmpw_mreq_s memReq;
  logic memRspValid;
  logic [63:0] memRdata;
  logic [3:0] psSel = 4'h0;
  logic slow = 1'b0;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  lmpw_pkg::lmpw_xrsp_s expq[$];
  lmpw_pkg::lmpw_xrsp_s e;
  logic [63:0] rootVal;
  always #4 core_clk = ~core_clk;
  lmpw_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xreqValid(xreqValid), .xreq(xreq),
    .xreqReady(xreqReady), .xrspValid(xrspValid), .xrsp(xrsp), .memReqValid(memReqValid),
    .memReq(memReq), .memRspValid(memRspValid), .memRdata(memRdata));
  lmpw_mem_model u_mem (.core_clk(core_clk), .rst_n(rst_n), .memReqValid(memReqValid),
    .memReq(memReq), .psSel(psSel), .slow(slow), .memRspValid(memRspValid),
    .memRdata(memRdata));
  task final_report;
    $display("comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= w ? 4'hf : 4'h0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic err;
    apb(1'b0, a, 32'h0, r, err);
    chk(r, exp, "read data");
    chk(err, eexp, "slave error");
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic err;
    apb(1'b1, a, d, r, err);
  endtask
  function automatic lmpw_pkg::lmpw_xrsp_s expect_rsp(input logic [63:0] v,
                                                     input logic stk, input logic [3:0] ps);
    lmpw_pkg::lmpw_xrsp_s r;
    logic [51:0] a;
    logic [63:0] en;
    r = '0;
    if (v[63:47] != 17'h0 && v[63:47] != 17'h1ffff) begin
      r.fault = stk ? lmpw_pkg::FLT_SS : lmpw_pkg::FLT_GP;
      return r;
    end
    a = {rootVal[51:12], v[47:39], 3'h0};
    for (int l = 0; l < 4; l++) begin
      en = u_mem.f_entry(a, 2'(l), ps[l]);
      r.noExecute = r.noExecute | en[63];
      if (l == 1 && en[7]) begin
        r.size = lmpw_pkg::SZ_1G;
        r.paddr = {en[51:30], v[29:0]};
        return r;
      end
      if (l == 2 && en[7]) begin
        r.size = lmpw_pkg::SZ_2M;
        r.paddr = {en[51:21], v[20:0]};
        return r;
      end
      r.paddr = {en[51:12], v[11:0]};
      a = {en[51:12], 9'(v >> (30 - 9 * l)), 3'h0};
    end
    return r;
  endfunction
  task xlate(input logic [63:0] v, input logic stk, input logic [3:0] ps, input logic s);
    @(posedge core_clk);
    while (xreqReady !== 1'b1) @(posedge core_clk);
    psSel <= ps;
    slow <= s;
    xreqValid <= 1'b1;
    xreq <= '{vaddr: v, isStack: stk};
    expq.push_back(expect_rsp(v, stk, ps));
    @(posedge core_clk);
    while (xreqReady !== 1'b1) @(posedge core_clk);
    xreqValid <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (xrspValid === 1'b1) begin
      if (expq.size() == 0) chk(64'h1, 64'h0, "unexpected response");
      else begin
        e = expq.pop_front();
        if (e.fault != lmpw_pkg::FLT_NONE) chk(64'(xrsp.fault), 64'(e.fault), "fault");
        else chk(64'(xrsp), 64'(e), "translation");
      end
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    logic [63:0] v;
    logic [3:0] ps;
    int k;
    void'($urandom(32'h60c69ca5));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd(lmpw_pkg::OFF_ROOT_LO, 32'h0, 1'b0);
    rd(lmpw_pkg::OFF_ROOT_HI, 32'h0, 1'b0);
    rd(lmpw_pkg::OFF_CTRL, 32'h0, 1'b0);
    rd(lmpw_pkg::OFF_STATUS, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    chk(64'(xreqReady), 64'h0, "ready before activation");
    $display("test registers done");
    wr(lmpw_pkg::OFF_CTRL, 32'h2);
    rd(lmpw_pkg::OFF_STATUS, 32'h1, 1'b0);
    wr(lmpw_pkg::OFF_STATUS, 32'h1);
    wr(lmpw_pkg::OFF_CTRL, 32'h3);
    rd(lmpw_pkg::OFF_STATUS, 32'h2, 1'b0);
    $display("test activation done");
    // reserved fields and bits above the address width stay zero
    rootVal = {$urandom, $urandom} & 64'h000fffff_fffff018;
    wr(lmpw_pkg::OFF_ROOT_LO, rootVal[31:0]);
    wr(lmpw_pkg::OFF_ROOT_HI, rootVal[63:32]);
    rd(lmpw_pkg::OFF_ROOT_HI, rootVal[63:32], 1'b0);
    for (int i = 0; i < 16; i++) begin
      if (i == 8) wr(lmpw_pkg::OFF_CTRL, 32'h7);
      v = {$urandom, $urandom};
      v = {{16{v[47]}}, v[47:0]};
      if (i % 4 == 3) v[55] = ~v[55];
      ps = (i % 4 == 0) ? 4'h0 : (i % 4 == 1) ? 4'h4 : (i % 4 == 2) ? 4'h2 : 4'($urandom);
      xlate(v, 1'($urandom), ps, 1'($urandom));
    end
    for (k = 0; k < 300 && expq.size() != 0; k++) @(posedge core_clk);
    chk(64'(expq.size()), 64'h0, "responses missing");
    $display("test translation done");
    final_report();
  end
endmodule // tb
